//--- pkg/rtc_pwr_regs.svh
/*
 * Register indices, field positions and reset values of the wake-pin,
 * clock-output and retained-word register bank.
 * Assumes a 16-bit register port with a 3-bit word index.
 */
`ifndef RTC_PWR_REGS_SVH
`define RTC_PWR_REGS_SVH

`define PCTL_IDX          3'h0
`define RW1_IDX           3'h1
`define RW2_IDX           3'h2
`define RW3_IDX           3'h3
`define RW4_IDX           3'h4

`define WAKE_LVL_BIT      4
`define WAKE_DIR_BIT      3
`define BANDGAP_PD_BIT    2
`define REGULATOR_PD_BIT  1
`define CLKOUT_EN_BIT     0
`define PCTL_FIELD_MSB    4

`define PCTL_RESET        5'h00
`define RW_RESET          16'h0000
`define RSVD_READ         11'h000

`endif

//--- pkg/rtc_pwr_pkg.sv
/*
 * Types shared by the wake-pin and retained-word register bank.
 * Assumes the register header is compiled alongside it.
 */
package rtc_pwr_pkg;

    typedef logic [15:0] word_t;
    typedef logic [2:0]  idx_t;

    // Field order gives bit 4 down to bit 0 of the control register.
    typedef struct packed {
        logic wake_output_level;
        logic wake_direction;
        logic bandgap_powerdown;
        logic regulator_powerdown;
        logic clock_output_enable;
    } pctl_s;

    typedef struct packed {
        logic wake_out;
        logic wake_oe_n;
        logic clkout;
        logic wake_event;
    } pin_out_s;

endpackage

//--- verilog/sync_2ff.sv
/*
 * Two-flop synchroniser for a single asynchronous level.
 * Assumes the caller reads only the synchronised output.
 */
`timescale 1ns/1ps
module sync_2ff (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;
    logic meta_next;
    logic q_reg;
    logic q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q_reg    <= 1'b0;
        end else if (ce) begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;
endmodule // sync_2ff

//--- verilog/retained_word.sv
/*
 * One 16-bit software word kept in the always-on domain.
 * Assumes write strobe and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "rtc_pwr_regs.svh"
module retained_word
    import rtc_pwr_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ce,
    input  wire logic  clr,
    input  wire logic  we,
    input  wire word_t wdata,
    output word_t      q
);
    word_t value_reg;
    word_t value_next;

    always_comb begin
        value_next = value_reg;
        if (clr) begin
            value_next = `RW_RESET;
        end else if (we) begin
            value_next = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            value_reg <= `RW_RESET;
        end else if (ce) begin
            value_reg <= value_next;
        end
    end

    assign q = value_reg;
endmodule // retained_word

//--- verilog/rtc_pwr_bank.sv
/*
 * Wake-pin control, clock-output gate and four retained words.
 * Assumes this sits in the always-on clock domain, that the register
 * port is on the same clock, and that the interrupt block supplies the
 * external event enable as a same-domain level.
 */
`timescale 1ns/1ps
`include "rtc_pwr_regs.svh"
module rtc_pwr_bank
    import rtc_pwr_pkg::*;
(
    input  wire logic  CLK,
    input  wire logic  RST,
    input  wire logic  CE,
    input  wire idx_t  ADDR,
    input  wire word_t WDATA,
    input  wire logic  WR,
    input  wire logic  RD,
    output word_t      RDATA,
    input  wire logic  BLOCK_SOFT_RESET,
    input  wire logic  EXTERNAL_EVENT_IRQ_ENABLE,
    input  wire logic  WAKE_PIN_IN,
    output logic       WAKE_PIN_OUT,
    output logic       WAKE_PIN_OE_N,
    input  wire logic  REF_CLK_IN,
    output logic       CLKOUT,
    output logic       WAKE_EVENT
);

    pctl_s    pctl_reg;
    pctl_s    pctl_next;
    pin_out_s pins_reg;
    pin_out_s pins_next;
    word_t    rdata_reg;
    word_t    rdata_next;
    logic     wake_prev_reg;
    logic     wake_prev_next;
    logic     wake_sync;
    logic     ref_sync;
    logic     wake_rise;
    logic     pctl_we;
    logic     [3:0] word_we;
    word_t    words [4];

    // Both external levels are asynchronous to CLK.
    sync_2ff u_wake_sync (
        .clk (CLK),
        .rst (RST),
        .ce  (CE),
        .d   (WAKE_PIN_IN),
        .q   (wake_sync)
    );

    sync_2ff u_ref_sync (
        .clk (CLK),
        .rst (RST),
        .ce  (CE),
        .d   (REF_CLK_IN),
        .q   (ref_sync)
    );

    // Retained words.

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_word
            assign word_we[gi] = WR && (ADDR == (`RW1_IDX + 3'(gi)));

            retained_word u_word (
                .clk   (CLK),
                .rst   (RST),
                .ce    (CE),
                .clr   (BLOCK_SOFT_RESET),
                .we    (word_we[gi]),
                .wdata (WDATA),
                .q     (words[gi])
            );
        end
    endgenerate

    // Control register.

    assign pctl_we = WR && (ADDR == `PCTL_IDX);

    always_comb begin
        pctl_next = pctl_reg;
        if (BLOCK_SOFT_RESET) begin
            pctl_next = `PCTL_RESET;
        end else if (pctl_we) begin
            // Only bits 4..0 are kept; the rest of the write is dropped.
            pctl_next = pctl_s'(WDATA[`PCTL_FIELD_MSB:0]);
        end
    end
    // The two power-down bits are stored so software reads back what it
    // wrote, but nothing in this block acts on them.

    always_ff @(posedge CLK) begin
        if (RST) begin
            pctl_reg <= `PCTL_RESET;
        end else if (CE) begin
            pctl_reg <= pctl_next;
        end
    end

    // Read port.

    always_comb begin
        rdata_next = `RW_RESET;
        if (RD) begin
            case (ADDR)
                `PCTL_IDX: rdata_next = {`RSVD_READ, pctl_reg};
                `RW1_IDX:  rdata_next = words[0];
                `RW2_IDX:  rdata_next = words[1];
                `RW3_IDX:  rdata_next = words[2];
                `RW4_IDX:  rdata_next = words[3];
                default:   rdata_next = `RW_RESET;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_reg <= `RW_RESET;
        end else if (CE) begin
            rdata_reg <= rdata_next;
        end
    end

    // Pin logic.

    // While the pin is an output the synchroniser sees our own drive, so
    // the event detector is gated by direction to avoid self-triggering.
    assign wake_rise = wake_sync && !wake_prev_reg;

    always_comb begin
        wake_prev_next = wake_sync;
        pins_next      = pins_reg;
        // The pad only ever sinks; high comes from the outside pull-up.
        pins_next.wake_out   = 1'b0;
        pins_next.wake_oe_n  = !(pctl_reg.wake_direction
                                 && !pctl_reg.wake_output_level);
        pins_next.clkout     = pctl_reg.clock_output_enable && ref_sync;
        pins_next.wake_event = wake_rise && !pctl_reg.wake_direction
                               && EXTERNAL_EVENT_IRQ_ENABLE;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_prev_reg <= 1'b0;
            pins_reg      <= '{wake_out: 1'b0, wake_oe_n: 1'b1, clkout: 1'b0, wake_event: 1'b0};
        end else if (CE) begin
            wake_prev_reg <= wake_prev_next;
            pins_reg      <= pins_next;
        end
    end

    assign RDATA         = rdata_reg;
    assign WAKE_PIN_OUT  = pins_reg.wake_out;
    assign WAKE_PIN_OE_N = pins_reg.wake_oe_n;
    assign CLKOUT        = pins_reg.clkout;
    assign WAKE_EVENT    = pins_reg.wake_event;

    // Checks.

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_wake_drive_low: assert property (
        CE |=> (WAKE_PIN_OE_N == !($past(pctl_reg.wake_direction)
                                   && !$past(pctl_reg.wake_output_level)))
    ) else $error("Wake pin drive does not follow level and direction.");

    a_wake_input_released: assert property (
        (CE && !pctl_reg.wake_direction) |=> WAKE_PIN_OE_N
    ) else $error("Wake pin driven while configured as input.");

    a_wake_never_high: assert property (
        !WAKE_PIN_OE_N |-> !WAKE_PIN_OUT
    ) else $error("Wake pin driven high.");

    a_event_on_rise: assert property (
        (CE && wake_rise && !pctl_reg.wake_direction && EXTERNAL_EVENT_IRQ_ENABLE) |=> WAKE_EVENT
    ) else $error("Wake input rise missed.");

    a_event_needs_enable: assert property (
        ($past(CE) && WAKE_EVENT) |-> ($past(EXTERNAL_EVENT_IRQ_ENABLE) && !$past(pctl_reg.wake_direction))
    ) else $error("Wake event raised without enable or as output.");

    a_clkout_gated: assert property (
        (CE && !pctl_reg.clock_output_enable) |=> !CLKOUT
    ) else $error("Clock output active while disabled.");

    a_rsvd_read_zero: assert property (
        (CE && RD && ADDR == `PCTL_IDX) |=> (RDATA[15:5] == `RSVD_READ)
    ) else $error("Reserved control bits read non-zero.");

    a_word_readback: assert property (
        (CE && WR && ADDR == `RW3_IDX && !BLOCK_SOFT_RESET) |=> (words[2] == $past(WDATA))
    ) else $error("Retained word differs from the value written.");

    a_pctl_write_back: assert property (
        (CE && pctl_we && !BLOCK_SOFT_RESET) |=> (pctl_reg == $past(WDATA[4:0]))
    ) else $error("Control fields not stored from write.");

    a_soft_reset_clears: assert property (
        (CE && BLOCK_SOFT_RESET) |=> (pctl_reg == `PCTL_RESET && words[2] == `RW_RESET
                                      && words[3] == `RW_RESET)
    ) else $error("Soft reset left state behind.");

    a_rdata_one_cycle: assert property (
        (CE && !RD) |=> (RDATA == `RW_RESET)
    ) else $error("Read data stands beyond its cycle.");

endmodule // rtc_pwr_bank

//--- testbench/wake_pullup_model.sv
/*
 * Outside circuit on the open-drain wake pin: a pull-up and a driver.
 * Assumes the device drives only while its active-low enable is low.
 */
`timescale 1ns/1ps
module wake_pullup_model (
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    input  wire logic ext_drive,
    input  wire logic ext_level,
    output logic      pin_level
);
    // The pin only sinks current, so the pull-up sets the idle level.
    always_comb begin
        if (!dev_oe_n) begin
            pin_level = dev_out;
        end else if (ext_drive) begin
            pin_level = ext_level;
        end else begin
            pin_level = 1'b1;
        end
    end
endmodule // wake_pullup_model

//--- testbench/rtc_power_pin_and_retained_words_tb_top.sv
/*
 * Self-checking bench for the wake-pin and retained-word bank.
 * Assumes one 40 MHz clock and the pull-up model on the wake pin.
 */
`timescale 1ns/1ps
module rtc_power_pin_and_retained_words_tb_top;
    import rtc_pwr_pkg::*;
    logic  CLK, RST, CE, WR, RD, SRST, EN, REF, DRV, LVL, PIN;
    logic  OUT, OE_N, CLKOUT, EV;
    idx_t  ADDR;
    word_t WDATA, RDATA;
    int    n_errors = 0;
    int    checks_done = 0;

    rtc_pwr_bank u_rtc_pwr_bank (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BLOCK_SOFT_RESET(SRST),
        .EXTERNAL_EVENT_IRQ_ENABLE(EN), .WAKE_PIN_IN(PIN), .WAKE_PIN_OUT(OUT),
        .WAKE_PIN_OE_N(OE_N), .REF_CLK_IN(REF), .CLKOUT(CLKOUT), .WAKE_EVENT(EV));
    wake_pullup_model u_wake_pullup_model (.dev_out(OUT), .dev_oe_n(OE_N),
        .ext_drive(DRV), .ext_level(LVL), .pin_level(PIN));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic chk(input string what, input word_t exp, input word_t got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input idx_t a, input word_t d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input idx_t a, input word_t exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk($sformatf("word %0d", a), exp, RDATA);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 5; i++) rd(idx_t'(i), 16'h0000);
        chk("oe_n", 16'h0001, word_t'(OE_N));
        chk("clkout", 16'h0000, word_t'(CLKOUT));
        $display("test reset done");
    endtask

    task automatic t_words();
        word_t v[4] = '{16'hFFFF, 16'h0001, 16'hA5C3, 16'h8000};
        for (int i = 1; i < 5; i++) wr(idx_t'(i), v[i-1]);
        wr(3'h5, 16'hFFFF);
        for (int i = 1; i < 5; i++) rd(idx_t'(i), v[i-1]);
        rd(3'h5, 16'h0000);
        $display("test words done");
    endtask

    task automatic t_ctrl();
        wr(3'h0, 16'hFFFF);
        rd(3'h0, 16'h001F);
        wr(3'h0, 16'h0008);
        wait_clk(1);
        chk("oe_n out", 16'h0000, word_t'(OE_N));
        chk("pin low", 16'h0000, word_t'(PIN));
        chk("out", 16'h0000, word_t'(OUT));
        wr(3'h0, 16'h0018);
        wait_clk(1);
        chk("oe_n rel", 16'h0001, word_t'(OE_N));
        chk("pin up", 16'h0001, word_t'(PIN));
        $display("test control done");
    endtask

    // A write offered while the enable is low must leave the word untouched.
    task automatic t_freeze();
        @(posedge CLK);
        CE <= 1'b0;
        WR <= 1'b1;
        ADDR <= 3'h1;
        WDATA <= 16'h5A5A;
        @(posedge CLK);
        WR <= 1'b0;
        CE <= 1'b1;
        rd(3'h1, 16'hFFFF);
        $display("test clock enable done");
    endtask

    task automatic t_clkout();
        word_t m[2] = '{16'h0001, 16'h0000};
        for (int i = 0; i < 2; i++) begin
            wr(3'h0, m[i]);
            REF <= 1'b1;
            wait_clk(4);
            chk("clkout hi", m[i], word_t'(CLKOUT));
            REF <= 1'b0;
            wait_clk(4);
            chk("clkout lo", 16'h0000, word_t'(CLKOUT));
        end
        $display("test clock output done");
    endtask

    task automatic t_wake();
        word_t ctl[3] = '{16'h0000, 16'h0000, 16'h0018};
        logic  ena[3] = '{1'b1, 1'b0, 1'b1};
        int    k;
        DRV <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(3'h0, ctl[i]);
            EN <= ena[i];
            wait_clk(4);
            k = 0;
            LVL <= 1'b1;
            repeat (8) begin
                wait_clk(1);
                if (EV === 1'b1) k++;
            end
            chk("events", (i == 0) ? 16'h0001 : 16'h0000, word_t'(k));
            LVL <= 1'b0;
            wait_clk(4);
        end
        DRV <= 1'b0;
        $display("test wake done");
    endtask

    task automatic t_soft();
        wr(3'h3, 16'h1234);
        wr(3'h0, 16'h0009);
        @(posedge CLK);
        SRST <= 1'b1;
        @(posedge CLK);
        SRST <= 1'b0;
        // Software stays off the port for three slow-clock periods.
        wait_clk(3700);
        rd(3'h3, 16'h0000);
        rd(3'h0, 16'h0000);
        $display("test soft reset done");
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        RST = 1'b1; CE = 1'b1; WR = 1'b0; RD = 1'b0; SRST = 1'b0; EN = 1'b0;
        REF = 1'b0; DRV = 1'b0; LVL = 1'b0; ADDR = 3'h0; WDATA = 16'h0000;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_words();
        t_ctrl();
        t_freeze();
        t_clkout();
        t_wake();
        t_soft();
        wrap_up();
    end

    initial begin
        #(25 * 10000);
        n_errors++;
        wrap_up();
    end
endmodule // rtc_power_pin_and_retained_words_tb_top
